// ### logic/spr_result_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "spr_map.vh"

module spr_result_regs #(
    parameter CT_SCALE = 1
) (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire [7:0]  reg_ptr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [15:0] adc_shunt_raw,
    input  wire [15:0] adc_bus_raw,
    output reg  [15:0] reg_rdata,
    output reg         conversion_done_flag,
    output reg         conv_busy
);

    // ------------------------------------------------------------------------
    // State codes.
    // ------------------------------------------------------------------------
    localparam ST_IDLE  = 2'd0;
    localparam ST_SHUNT = 2'd1;
    localparam ST_BUS   = 2'd2;
    localparam ST_MATH  = 2'd3;

    // ------------------------------------------------------------------------
    // Conversion time lookup in clock cycles.
    // ------------------------------------------------------------------------
    function [19:0] ct_cycles;
        input [2:0] sel;
        reg   [31:0] us;
        reg   [31:0] cyc;
        begin
            case (sel)
                3'd0:    us = `SPR_CT0_US;
                3'd1:    us = `SPR_CT1_US;
                3'd2:    us = `SPR_CT2_US;
                3'd3:    us = `SPR_CT3_US;
                3'd4:    us = `SPR_CT4_US;
                3'd5:    us = `SPR_CT5_US;
                3'd6:    us = `SPR_CT6_US;
                default: us = `SPR_CT7_US;
            endcase
            cyc       = us * `SPR_CLK_MHZ / CT_SCALE;
            ct_cycles = cyc[19:0];
        end
    endfunction

    function [3:0] avg_log2;
        input [2:0] sel;
        begin
            case (sel)
                3'd0:    avg_log2 = 4'd0;
                3'd1:    avg_log2 = 4'd2;
                3'd2:    avg_log2 = 4'd4;
                3'd3:    avg_log2 = 4'd6;
                3'd4:    avg_log2 = 4'd7;
                3'd5:    avg_log2 = 4'd8;
                3'd6:    avg_log2 = 4'd9;
                default: avg_log2 = 4'd10;
            endcase
        end
    endfunction

    reg  [15:0] config_reg;
    reg  [15:0] shunt_reg;
    reg  [15:0] bus_reg;
    reg  [15:0] power_reg;
    reg  [15:0] current_reg;
    reg  [15:0] calib_reg;
    reg  [1:0]  state_reg;
    reg  [19:0] timer_reg;
    reg  [10:0] sample_reg;
    reg  [26:0] sh_acc_reg;
    reg  [26:0] bus_acc_reg;
    reg         sh_pend_reg;
    reg         bus_pend_reg;

    wire [2:0]  mode        = config_reg[`SPR_CFG_MODE_HI:`SPR_CFG_MODE_LO];
    wire [2:0]  shunt_conv_time_sel = config_reg[`SPR_CFG_VSHT_HI:`SPR_CFG_VSHT_LO];
    wire [2:0]  sample_average_count = config_reg[`SPR_CFG_AVG_HI:`SPR_CFG_AVG_LO];
    wire [3:0]  avg_sh      = avg_log2(sample_average_count);
    wire [10:0] avg_n       = 11'h001 << avg_sh;
    wire        do_shunt    = mode[0];
    wire        do_bus      = mode[1];
    wire        powered     = mode[1] | mode[0];
    wire        cfg_wr      = reg_wr && (reg_ptr == `SPR_PTR_CONFIG);
    wire        soft_rst    = cfg_wr && reg_wdata[`SPR_CFG_RST_BIT];

    // ------------------------------------------------------------------------
    // Averaged readings and the math.
    // ------------------------------------------------------------------------
    wire signed [26:0] sh_avg  = $signed(sh_acc_reg) >>> avg_sh;
    wire        [26:0] bus_avg = bus_acc_reg >> avg_sh;
    wire        [15:0] sh_new   = do_shunt ? sh_avg[15:0] : shunt_reg;
    wire        [15:0] bus_new  = do_bus ? {1'b0, bus_avg[14:0]} : bus_reg;
    wire signed [31:0] cur_full = $signed(sh_new) * $signed({1'b0, calib_reg[14:0]});
    wire signed [31:0] cur_shr  = cur_full >>> `SPR_CALIB_SHIFT;
    wire signed [31:0] pwr_full = $signed(cur_shr[15:0]) * $signed({16'h0000, bus_new});
    wire        [31:0] pwr_abs  = pwr_full[31] ? -pwr_full : pwr_full;
    wire        [31:0] pwr_div  = pwr_abs / `SPR_POWER_DIV;

    // ------------------------------------------------------------------------
    // Conversion sequencer and registers.
    // ------------------------------------------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            config_reg           <= `SPR_CONFIG_RESET;
            shunt_reg            <= `SPR_RESULT_RESET;
            bus_reg              <= `SPR_RESULT_RESET;
            power_reg            <= `SPR_RESULT_RESET;
            current_reg          <= `SPR_RESULT_RESET;
            calib_reg            <= `SPR_CALIB_RESET;
            state_reg            <= ST_IDLE;
            timer_reg            <= 20'h00000;
            sample_reg           <= 11'h000;
            sh_acc_reg           <= 27'h0000000;
            bus_acc_reg          <= 27'h0000000;
            sh_pend_reg          <= 1'b0;
            bus_pend_reg         <= 1'b0;
            conversion_done_flag <= 1'b0;
            conv_busy            <= 1'b0;
        end else if (soft_rst) begin
            config_reg           <= `SPR_CONFIG_RESET;
            shunt_reg            <= `SPR_RESULT_RESET;
            bus_reg              <= `SPR_RESULT_RESET;
            power_reg            <= `SPR_RESULT_RESET;
            current_reg          <= `SPR_RESULT_RESET;
            calib_reg            <= `SPR_CALIB_RESET;
            state_reg            <= ST_IDLE;
            sh_pend_reg          <= 1'b1;
            bus_pend_reg         <= 1'b1;
            conversion_done_flag <= 1'b0;
            conv_busy            <= 1'b0;
        end else if (cfg_wr) begin
            config_reg   <= {1'b0, reg_wdata[14:0]};
            state_reg    <= ST_IDLE;
            conv_busy    <= 1'b0;
            sh_pend_reg  <= 1'b1;
            bus_pend_reg <= 1'b1;
            if (reg_wdata[1:0] != 2'b00) begin
                conversion_done_flag <= 1'b0;
            end
        end else begin
            if (reg_wr && reg_ptr == `SPR_PTR_CALIB) begin
                calib_reg <= {1'b0, reg_wdata[14:0]};
            end
            if (reg_rd && reg_ptr == `SPR_PTR_MASK) begin
                conversion_done_flag <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (powered && (config_reg[2] || sh_pend_reg)) begin
                        sh_pend_reg  <= 1'b0;
                        bus_pend_reg <= 1'b0;
                        conv_busy    <= 1'b1;
                        sample_reg   <= 11'h000;
                        sh_acc_reg   <= 27'h0000000;
                        bus_acc_reg  <= 27'h0000000;
                        timer_reg    <= ct_cycles(shunt_conv_time_sel);
                        state_reg    <= do_shunt ? ST_SHUNT : ST_BUS;
                    end
                end
                ST_SHUNT: begin
                    if (timer_reg > 20'h00001) begin
                        timer_reg <= timer_reg - 20'h00001;
                    end else begin
                        sh_acc_reg <= sh_acc_reg + {{11{adc_shunt_raw[15]}}, adc_shunt_raw};
                        timer_reg  <= ct_cycles(shunt_conv_time_sel);
                        state_reg  <= do_bus ? ST_BUS : ST_MATH;
                        if (!do_bus) begin
                            sample_reg <= sample_reg + 11'h001;
                        end
                    end
                end
                ST_BUS: begin
                    if (timer_reg > 20'h00001) begin
                        timer_reg <= timer_reg - 20'h00001;
                    end else begin
                        bus_acc_reg <= bus_acc_reg + {12'h000, adc_bus_raw[14:0]};
                        timer_reg   <= ct_cycles(shunt_conv_time_sel);
                        sample_reg  <= sample_reg + 11'h001;
                        state_reg   <= ST_MATH;
                    end
                end
                default: begin
                    if (sample_reg < avg_n) begin
                        state_reg <= do_shunt ? ST_SHUNT : ST_BUS;
                    end else begin
                        if (do_shunt) begin
                            shunt_reg <= sh_avg[15:0];
                        end
                        if (do_bus) begin
                            bus_reg <= {1'b0, bus_avg[14:0]};
                        end
                        current_reg          <= cur_shr[15:0];
                        power_reg            <= pwr_div[15:0];
                        conversion_done_flag <= 1'b1;
                        conv_busy            <= 1'b0;
                        state_reg            <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Read data, registered.
    // ------------------------------------------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_ptr == `SPR_PTR_CONFIG) begin
            reg_rdata <= config_reg;
        end else if (reg_ptr == `SPR_PTR_SHUNT) begin
            reg_rdata <= shunt_reg;
        end else if (reg_ptr == `SPR_PTR_BUS) begin
            reg_rdata <= bus_reg;
        end else if (reg_ptr == `SPR_PTR_POWER) begin
            reg_rdata <= power_reg;
        end else if (reg_ptr == `SPR_PTR_CURRENT) begin
            reg_rdata <= current_reg;
        end else if (reg_ptr == `SPR_PTR_CALIB) begin
            reg_rdata <= calib_reg;
        end else if (reg_ptr == `SPR_PTR_MASK) begin
            reg_rdata <= {12'h000, conversion_done_flag, 3'b000};
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // spr_result_regs
`default_nettype wire

// ### logic/spr_map.vh
`ifndef SPR_MAP_VH
`define SPR_MAP_VH
// ----------------------------------------------------------------------------
// Register pointers.
// ----------------------------------------------------------------------------
`define SPR_PTR_CONFIG      8'h00
`define SPR_PTR_SHUNT       8'h01
`define SPR_PTR_BUS         8'h02
`define SPR_PTR_POWER       8'h03
`define SPR_PTR_CURRENT     8'h04
`define SPR_PTR_CALIB       8'h05
`define SPR_PTR_MASK        8'h06
// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define SPR_CFG_RST_BIT     15
`define SPR_CFG_AVG_HI      11
`define SPR_CFG_AVG_LO      9
`define SPR_CFG_VSHT_HI     5
`define SPR_CFG_VSHT_LO     3
`define SPR_CFG_MODE_HI     2
`define SPR_CFG_MODE_LO     0
`define SPR_MASK_DONE_BIT   3
// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define SPR_CONFIG_RESET    16'h4127
`define SPR_RESULT_RESET    16'h0000
`define SPR_CALIB_RESET     16'h0000
// ----------------------------------------------------------------------------
// Scaling and timing.
// ----------------------------------------------------------------------------
`define SPR_CALIB_SHIFT     11
`define SPR_POWER_DIV       20000
`define SPR_CLK_MHZ         50
`define SPR_CT0_US          140
`define SPR_CT1_US          204
`define SPR_CT2_US          332
`define SPR_CT3_US          588
`define SPR_CT4_US          1100
`define SPR_CT5_US          2116
`define SPR_CT6_US          4156
`define SPR_CT7_US          8244
`endif

// ### sim/spr_result_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// Port checker.
// ----------------------------------------------------------------------------
module spr_result_regs_chk (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_ptr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        conversion_done_flag,
    input wire logic        conv_busy,
    input wire logic [15:0] reg_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic cfg_wr;
    assign cfg_wr = reg_wr && reg_ptr == 8'h00;
    unmapped_read_a: assert property (reg_ptr > 8'h06 |=> reg_rdata == 16'h0000)
        else $error("unmapped pointer read nonzero");
    bus_msb_zero_a: assert property (reg_ptr == 8'h02 |=> !reg_rdata[15])
        else $error("bus result bit 15 set");
    calib_msb_zero_a: assert property (reg_ptr == 8'h05 |=> !reg_rdata[15])
        else $error("calibration bit 15 set");
    cfg_rst_clear_a: assert property (reg_ptr == 8'h00 |=> !reg_rdata[15])
        else $error("config bit 15 reads one");
    cfg_wr_clear_a: assert property (cfg_wr && reg_wdata[1:0] != 2'b00 |=> !conversion_done_flag)
        else $error("config write left done flag set");
    pd_idle_a: assert property (cfg_wr && reg_wdata[1:0] == 2'b00 && !reg_wdata[15] |-> ##2 !conv_busy [*3])
        else $error("power-down still converting");
    run_start_a: assert property (cfg_wr && reg_wdata[1:0] != 2'b00 |-> ##[1:3] conv_busy)
        else $error("no conversion after config write");
    done_after_run_a: assert property ($rose(conversion_done_flag) |-> !conv_busy && $past(conv_busy))
        else $error("done flag without finished set");
endmodule // spr_result_regs_chk

bind spr_result_regs spr_result_regs_chk u_chk (.clk(clk), .sys_rst(sys_rst), .reg_ptr(reg_ptr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .conversion_done_flag(conversion_done_flag),
    .conv_busy(conv_busy), .reg_rdata(reg_rdata));
`default_nettype wire

// ### sim/spr_adc_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// Sample source; lines scramble while no conversion runs.
// ----------------------------------------------------------------------------
module spr_adc_model (
    input wire logic         clk,
    input wire logic         sys_rst,
    input wire logic         conv_busy,
    input wire logic [15:0]  shunt_level,
    input wire logic [15:0]  bus_level,
    output var logic [15:0]  adc_shunt_raw,
    output var logic [15:0]  adc_bus_raw
);
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            adc_shunt_raw <= 16'h0000;
            adc_bus_raw <= 16'h0000;
        end else if (conv_busy) begin
            adc_shunt_raw <= shunt_level;
            adc_bus_raw <= bus_level;
        end else begin
            adc_shunt_raw <= ~adc_shunt_raw;
            adc_bus_raw <= ~adc_bus_raw;
        end
    end
endmodule // spr_adc_model
`default_nettype wire

// ### sim/spr_result_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
// ----------------------------------------------------------------------------
// Testbench.
// ----------------------------------------------------------------------------
module spr_result_regs_test;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_ptr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] sh_lvl = 16'h8300;
    logic [15:0] bus_lvl = 16'hffff;
    logic [15:0] adc_s, adc_b, reg_rdata, d;
    logic        flag, busy;
    int          err_count = 0;
    int          n_tests = 0;
    int          n;
    int          t[8] = '{7, 10, 16, 29, 55, 105, 207, 412};
    always #10 clk = ~clk;
    spr_result_regs #(.CT_SCALE(1000)) dut (.clk(clk), .sys_rst(sys_rst), .reg_ptr(reg_ptr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .adc_shunt_raw(adc_s),
        .adc_bus_raw(adc_b), .reg_rdata(reg_rdata), .conversion_done_flag(flag),
        .conv_busy(busy));
    spr_adc_model adc (.clk(clk), .sys_rst(sys_rst), .conv_busy(busy), .shunt_level(sh_lvl),
        .bus_level(bus_lvl), .adc_shunt_raw(adc_s), .adc_bus_raw(adc_b));
    task wr(input logic [7:0] p, input logic [15:0] v);
        @(negedge clk);
        reg_ptr = p;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] p, output logic [15:0] v);
        @(negedge clk);
        reg_ptr = p;
        reg_rd = 1'b1;
        @(negedge clk);
        v = reg_rdata;
        reg_rd = 1'b0;
    endtask
    task wait_flag;
        for (int i = 0; i < 3000 && flag !== 1'b1; i++) @(negedge clk);
        `CHK(flag, 1'b1)
    endtask
    task sets(input int k);
        repeat (k) begin
            wait_flag();
            rd(8'h06, d);
            `CHK(d, 16'h0008)
            `CHK(flag, 1'b0)
        end
    endtask
    task blen(output int c);
        c = 0;
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
        for (int i = 0; i < 3000 && busy !== 1'b1; i++) @(negedge clk);
        while (busy === 1'b1 && c < 3000) begin
            @(negedge clk);
            c++;
        end
    endtask
    task test_done;
        $display("mismatches %0d of %0d compares", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        rd(8'h00, d); `CHK(d, 16'h4127)
        rd(8'h05, d); `CHK(d, 16'h0000)
        sets(2);
        wr(8'h01, 16'h1234);
        rd(8'h01, d); `CHK(d, 16'h8300)
        rd(8'h02, d); `CHK(d, 16'h7fff)
        rd(8'h04, d); `CHK(d, 16'h0000)
        rd(8'h03, d); `CHK(d, 16'h0000)
        rd(8'h07, d); `CHK(d, 16'h0000)
        wr(8'h05, 16'h8800);
        rd(8'h05, d); `CHK(d, 16'h0800)
        sets(3);
        rd(8'h04, d); `CHK(d, 16'h8300)
        rd(8'h03, d); `CHK(d, 16'hcccb)
        wait_flag();
        wr(8'h00, 16'h4127); `CHK(flag, 1'b0)
        for (int c = 0; c < 8; c++) begin
            wr(8'h00, 16'h4007 | 16'(c << 3));
            blen(n);
            `CHK(n, 2 * t[c] + 1)
        end
        for (int m = 0; m < 8; m++) begin
            wr(8'h00, 16'h4000 | 16'(m));
            repeat (3) @(negedge clk);
            `CHK(busy, m[1:0] != 2'b00)
            repeat (60) @(negedge clk);
            if (m < 4) `CHK(busy, 1'b0)
        end
        sh_lvl = 16'h0100;
        bus_lvl = 16'h1234;
        wr(8'h00, 16'h4003);
        repeat (60) @(negedge clk);
        rd(8'h01, d); `CHK(d, 16'h0100)
        rd(8'h02, d); `CHK(d, 16'h1234)
        rd(8'h04, d); `CHK(d, 16'h0100)
        rd(8'h03, d); `CHK(d, 16'h003b)
        wr(8'h00, 16'h8000);
        rd(8'h00, d); `CHK(d, 16'h4127)
        rd(8'h05, d); `CHK(d, 16'h0000)
        test_done();
    end
    // The full run needs about 3000 cycles; this allows well over five times that.
    initial begin
        #400000;
        err_count++;
        test_done();
    end
endmodule // spr_result_regs_test
`default_nettype wire
